// ---- hw/cqf_top.sv ----
// Capture and quadrature flag control with input noise filters.
// Assumes capture, reload and counter events are one-cycle pulses on
// SYS_CLK_I, direction is a level on SYS_CLK_I, capture pins are async.
`timescale 1ns/1ns
module cqf_top
   import cqf_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [APB_DW-1:0] PWDATA_I,
   output logic [APB_DW-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Capture input pins and filtered levels
   input wire logic [NUM_CH-1:0] CAP_PIN_I,
   output logic [NUM_CH-1:0] CAP_FILT_O,
   // Capture engine events
   input wire logic [NUM_CH-1:0] CAP_EVENT_I,
   input wire logic [NUM_CH-1:0] RELOAD_EVENT_I,
   // Quadrature decoder events
   input wire logic CNT_OVERFLOW_I,
   input wire logic CNT_UNDERFLOW_I,
   input wire logic CNT_WRAP_MAX_TO_ZERO_I,
   input wire logic CNT_WRAP_ZERO_TO_MAX_I,
   input wire logic DIRECTION_I,
   // Flags and interrupt
   output logic [NUM_CH-1:0] FLAG_O,
   output logic IRQ_O
);
   typedef struct packed {
      logic [2:0] fen;
      logic [2:0] flags;
      logic quad;
      logic cmp;
      logic dir_ie;
      logic [2:0] mask;
      logic [2:0] istat;
      logic dir_q;
      logic [APB_DW-1:0] prdata;
   } cqf_st_t;

   cqf_st_t st;
   cqf_st_t next_st;

   logic [NUM_CH-1:0] pin_sync;
   logic [NUM_CH-1:0] pin_filt;
   logic [2:0] set_ev;
   logic setup_ph;
   logic access_ph;
   logic hit;
   logic wr_en;
   logic dir_chg;
   cqf_sel_t sel;

   // Address decode shared by read and write paths
   function automatic logic addr_valid(input logic [APB_AW-1:0] a);
      return (a == OFS_FLAGS) || (a == OFS_MODE) ||
         (a == OFS_IRQ_MASK) || (a == OFS_IRQ_STAT);
   endfunction

   function automatic cqf_sel_t addr_sel(input logic [APB_AW-1:0] a);
      cqf_sel_t s;
      s = CQF_SEL_FLAGS;
      if (a == OFS_MODE) begin
         s = CQF_SEL_MODE;
      end else if (a == OFS_IRQ_MASK) begin
         s = CQF_SEL_MASK;
      end else if (a == OFS_IRQ_STAT) begin
         s = CQF_SEL_STAT;
      end
      return s;
   endfunction

   // Per-channel synchroniser and optional noise filter
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
         cqf_sync2 u_sync (
            .clk_i(SYS_CLK_I),
            .reset_n_i(RESET_N_I),
            .d_i(CAP_PIN_I[ch]),
            .q_o(pin_sync[ch])
         );
         cqf_noise_filter u_filt (
            .clk_i(SYS_CLK_I),
            .reset_n_i(RESET_N_I),
            .en_i(st.fen[ch]),
            .d_i(pin_sync[ch]),
            .q_o(pin_filt[ch])
         );
      end
   endgenerate

   assign setup_ph = PSEL_I && !PENABLE_I;
   assign access_ph = PSEL_I && PENABLE_I;
   assign hit = addr_valid(PADDR_I);
   assign sel = addr_sel(PADDR_I);
   assign wr_en = access_ph && PWRITE_I && hit;

   // Direction indication changed since last cycle
   assign dir_chg = DIRECTION_I != st.dir_q;

   // Hardware set sources per flag bit
   always_comb begin
      // Bit 0 is shared: its source follows the mode
      if (st.quad) begin
         if (st.cmp) begin
            set_ev[0] = CNT_WRAP_MAX_TO_ZERO_I || CNT_WRAP_ZERO_TO_MAX_I;
         end else begin
            set_ev[0] = CNT_OVERFLOW_I || CNT_UNDERFLOW_I;
         end
      end else begin
         set_ev[0] = CAP_EVENT_I[0] || RELOAD_EVENT_I[0];
      end
      if (st.quad) begin
         set_ev[1] = dir_chg && st.dir_ie;
      end else begin
         set_ev[1] = CAP_EVENT_I[1] || RELOAD_EVENT_I[1];
      end
      set_ev[2] = CAP_EVENT_I[2] || RELOAD_EVENT_I[2];
   end

   always_comb begin
      next_st = st;
      next_st.dir_q = DIRECTION_I;
      // Flags stay set until software writes zero; a set wins
      next_st.flags = st.flags | set_ev;
      next_st.istat = st.istat | set_ev;
      if (wr_en) begin
         unique case (sel)
            CQF_SEL_FLAGS: begin
               next_st.fen = PWDATA_I[FEN_LSB +: 3];
               next_st.flags = (st.flags & PWDATA_I[FLAG_LSB +: 3]) | set_ev;
            end
            CQF_SEL_MODE: begin
               next_st.quad = PWDATA_I[MODE_QUAD];
               next_st.cmp = PWDATA_I[MODE_CMP];
               next_st.dir_ie = PWDATA_I[MODE_DIR_IE];
            end
            CQF_SEL_MASK: begin
               next_st.mask = PWDATA_I[2:0];
            end
            CQF_SEL_STAT: begin
               next_st.istat = (st.istat & ~PWDATA_I[2:0]) | set_ev;
            end
         endcase
      end
      // Read data is captured in the setup cycle
      if (setup_ph) begin
         next_st.prdata = '0;
         if (!PWRITE_I && hit) begin
            unique case (sel)
               CQF_SEL_FLAGS: begin
                  next_st.prdata[FEN_LSB +: 3] = st.fen;
                  next_st.prdata[FLAG_LSB +: 3] = st.flags;
               end
               CQF_SEL_MODE: begin
                  next_st.prdata[MODE_QUAD] = st.quad;
                  next_st.prdata[MODE_CMP] = st.cmp;
                  next_st.prdata[MODE_DIR_IE] = st.dir_ie;
               end
               CQF_SEL_MASK: begin
                  next_st.prdata[2:0] = st.mask;
               end
               CQF_SEL_STAT: begin
                  next_st.prdata[2:0] = st.istat;
               end
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st.fen <= FEN_RST;
         st.flags <= FLAGS_RST;
         st.quad <= MODE_RST[MODE_QUAD];
         st.cmp <= MODE_RST[MODE_CMP];
         st.dir_ie <= MODE_RST[MODE_DIR_IE];
         st.mask <= MASK_RST;
         st.istat <= FLAGS_RST;
         st.dir_q <= 1'b0;
         st.prdata <= '0;
      end else begin
         st <= next_st;
      end
   end

   // No wait states: answer in the first access phase cycle
   assign PREADY_O = access_ph;
   assign PSLVERR_O = access_ph && !hit;
   assign PRDATA_O = st.prdata;
   assign CAP_FILT_O = pin_filt;
   assign FLAG_O = st.flags;
   assign IRQ_O = |(st.istat & st.mask);

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence clear_bit0_s;
      wr_en && sel == CQF_SEL_FLAGS && !PWDATA_I[0];
   endsequence

   sequence ic_event0_s;
      !st.quad && (CAP_EVENT_I[0] || RELOAD_EVENT_I[0]);
   endsequence

   ch0_capture_a: assert property (ic_event0_s |=> st.flags[0])
      else $error("channel 0 event did not set flag 0");

   quad_free_a: assert property (st.quad && !st.cmp &&
      (CNT_OVERFLOW_I || CNT_UNDERFLOW_I) |=> FLAG_O[0])
      else $error("counter overflow did not set the event flag");

   quad_compare_a: assert property (st.quad && st.cmp &&
      (CNT_WRAP_MAX_TO_ZERO_I || CNT_WRAP_ZERO_TO_MAX_I) |=> FLAG_O[0])
      else $error("counter wrap did not set the event flag");

   cmp_no_ovf_a: assert property (st.quad && st.cmp && !st.flags[0] &&
      !CNT_WRAP_MAX_TO_ZERO_I && !CNT_WRAP_ZERO_TO_MAX_I |=> !FLAG_O[0])
      else $error("event flag set without a wrap in compare mode");

   dir_change_a: assert property (st.quad && st.dir_ie &&
      DIRECTION_I != $past(DIRECTION_I) ##1 1'b1 |-> FLAG_O[1])
      else $error("direction change did not set flag 1");

   ch1_capture_a: assert property (!st.quad &&
      (CAP_EVENT_I[1] || RELOAD_EVENT_I[1]) |=> FLAG_O[1])
      else $error("channel 1 event did not set flag 1");

   ch2_capture_a: assert property ((CAP_EVENT_I[2] || RELOAD_EVENT_I[2])
      |=> FLAG_O[2] && st.istat[2])
      else $error("channel 2 event did not set flag 2");

   flag_hold_a: assert property (st.flags[1] &&
      !(wr_en && sel == CQF_SEL_FLAGS) |=> FLAG_O[1])
      else $error("flag 1 dropped without a software clear");

   set_wins_a: assert property (clear_bit0_s ##0 ic_event0_s |=> FLAG_O[0])
      else $error("hardware set lost against a clear");

   clear_works_a: assert property (clear_bit0_s ##0 !set_ev[0] |=> !FLAG_O[0])
      else $error("writing zero did not clear flag 0");

   filter_en_a: assert property (wr_en && sel == CQF_SEL_FLAGS
      |=> st.fen == $past(PWDATA_I[FEN_LSB +: 3]))
      else $error("filter enables not taken from the write");

   irq_level_a: assert property (st.istat[2] && st.mask[2] ##1 st.istat[2] |-> IRQ_O)
      else $error("unmasked status did not raise the interrupt");
endmodule

// ---- hw/cqf_pkg.sv ----
// Constants shared by the capture flag and filter control block.
// Assumes a single 125 MHz system clock and an APB register bus.
// Functional notes
// - Three enable bits route each capture input through its noise filter.
// - Flag bit 2 sets on channel 2 capture or reload; it is its request.
// - In capture mode flag bit 1 sets on channel 1 capture or reload.
// - In quadrature mode flag bit 1 sets on direction change when enabled.
// - Flag bit 0 is one bit; its meaning follows the operating mode.
// - In capture mode flag bit 0 sets on channel 0 capture or reload.
// - In quadrature free counting, bit 0 sets on counter overflow or underflow.
// - In quadrature compare counting, bit 0 sets on max-to-zero or zero-to-max wrap.
package cqf_pkg;
   localparam int NUM_CH = 3;
   localparam int APB_DW = 32;
   localparam int APB_AW = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;

   // Field positions in the flag register
   localparam int FLAG_LSB = 0;
   localparam int FEN_LSB = 3;
   // Field positions in the mode register
   localparam int MODE_QUAD = 0;
   localparam int MODE_CMP = 1;
   localparam int MODE_DIR_IE = 2;

   // Reset values
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [2:0] FEN_RST = 3'h0;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Noise filter: an input must hold its new level this long to pass
   localparam int CLK_PERIOD_NS = 8;
   localparam int FILTER_TIME_NS = 32;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] FILTER_LAST = 3'(FILTER_CYCLES - 1);

   typedef enum logic [1:0] {
      CQF_SEL_FLAGS,
      CQF_SEL_MODE,
      CQF_SEL_MASK,
      CQF_SEL_STAT
   } cqf_sel_t;
endpackage

// ---- hw/cqf_sync2.sv ----
// Two-stage synchroniser for one asynchronous pin level.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ns
module cqf_sync2
   import cqf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Data
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic meta;
      logic sync;
   } cqf_sync_st_t;

   cqf_sync_st_t st;
   cqf_sync_st_t next_st;

   always_comb begin
      next_st.meta = d_i;
      next_st.sync = st.meta;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.sync;
endmodule

// ---- hw/cqf_noise_filter.sv ----
// Noise filter for one synchronised capture input.
// Assumes the input is already in the system clock domain.
`timescale 1ns/1ns
module cqf_noise_filter
   import cqf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic en_i,
   // Data
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic q;
      logic [2:0] cnt;
   } cqf_filt_st_t;

   cqf_filt_st_t st;
   cqf_filt_st_t next_st;

   always_comb begin
      next_st = st;
      if (!en_i) begin
         next_st.q = d_i;
         next_st.cnt = 3'h0;
      end else if (d_i == st.q) begin
         next_st.cnt = 3'h0;
      end else if (st.cnt == FILTER_LAST) begin
         // Level held long enough: accept it
         next_st.q = d_i;
         next_st.cnt = 3'h0;
      end else begin
         next_st.cnt = st.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.q;

   filt_delay_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $past(en_i) && en_i && $changed(st.q) |-> $past(st.cnt) == FILTER_LAST)
      else $error("filtered level changed before the hold time");
endmodule

// ---- verification/cqf_src_model.sv ----
// Model of the capture pin sources and the decoder event sources.
// Assumes the bench calls its tasks; outputs change only after a rising edge.
`timescale 1ns/1ns
module cqf_src_model (
   // Clock
   input wire logic clk_i,
   // Sources
   output logic [2:0] pin_o,
   output logic [2:0] cap_o,
   output logic [2:0] rld_o,
   output logic [3:0] cnt_o,
   output logic dir_o
);
   initial begin
      pin_o = 3'h0;
      cap_o = 3'h0;
      rld_o = 3'h0;
      cnt_o = 4'h0;
      dir_o = 1'b0;
   end
   // Events are single-cycle pulses: {cap, reload, ovf, udf, max_to_zero, zero_to_max}
   task pulse(input logic [9:0] v);
      @(posedge clk_i);
      {cap_o, rld_o, cnt_o} <= v;
      @(posedge clk_i);
      {cap_o, rld_o, cnt_o} <= 10'h000;
   endtask
   task level(input logic [2:0] p, input logic d);
      @(posedge clk_i);
      pin_o <= p;
      dir_o <= d;
   endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the capture flag and filter control block.
// Assumes the APB answers without wait states and events are one cycle wide.
`timescale 1ns/1ns
module testbench;
   import cqf_pkg::*;
   logic clk, rst_n, psel, pen, pwr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq, dir;
   logic [2:0] filt, flag, pin, cap, rld;
   logic [3:0] cnt;
   int n_errors, num_checks;
   localparam logic [2:0] TM [13] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 3, 3, 3, 1};
   localparam logic [9:0] TV [13] = '{'h200, 'h020, 'h080, 'h010, 'h008, 'h080, 'h008,
      'h004, 'h002, 'h008, 'h002, 'h001, 'h200};
   localparam logic [2:0] TE [13] = '{4, 2, 1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 4};

   cqf_src_model src (.clk_i(clk), .pin_o(pin), .cap_o(cap), .rld_o(rld), .cnt_o(cnt),
      .dir_o(dir));
   cqf_top DUT (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CAP_PIN_I(pin), .CAP_FILT_O(filt),
      .CAP_EVENT_I(cap), .RELOAD_EVENT_I(rld), .CNT_OVERFLOW_I(cnt[3]),
      .CNT_UNDERFLOW_I(cnt[2]), .CNT_WRAP_MAX_TO_ZERO_I(cnt[1]),
      .CNT_WRAP_ZERO_TO_MAX_I(cnt[0]), .DIRECTION_I(dir), .FLAG_O(flag), .IRQ_O(irq));

   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task flag_is(input logic [2:0] e);
      @(negedge clk);
      chk("flag", {29'h0, e}, {29'h0, flag});
   endtask
   task t_reset;
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk("flag reg", 32'h0, rd);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode reg", 32'h0, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
   endtask
   task t_events;
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, OFS_MODE, {29'h0, TM[i]});
         src.pulse(TV[i]);
         flag_is(TE[i]);
         apb(1'b0, OFS_FLAGS, 32'h0);
         chk("flag reg", {29'h0, TE[i]}, rd);
         apb(1'b1, OFS_FLAGS, 32'h0);
         flag_is(3'h0);
      end
      $display("test events done");
   endtask
   task t_irq;
      apb(1'b1, OFS_MODE, 32'h0);
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      src.pulse(10'h020);
      @(negedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      src.pulse(10'h200);
      @(negedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h6, rd);
      apb(1'b1, OFS_IRQ_STAT, 32'h4);
      @(negedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      fork
         apb(1'b1, OFS_FLAGS, 32'h0);
         begin
            @(posedge clk);
            src.pulse(10'h200);
         end
      join
      flag_is(3'h4);
      apb(1'b1, OFS_FLAGS, 32'h0);
      $display("test irq done");
   endtask
   task t_dir;
      apb(1'b1, OFS_MODE, 32'h1);
      src.level(3'h0, 1'b1);
      repeat (2) @(posedge clk);
      flag_is(3'h0);
      apb(1'b1, OFS_MODE, 32'h5);
      src.level(3'h0, 1'b0);
      repeat (2) @(posedge clk);
      flag_is(3'h2);
      repeat (10) @(posedge clk);
      flag_is(3'h2);
      apb(1'b1, OFS_FLAGS, 32'h0);
      flag_is(3'h0);
      $display("test direction done");
   endtask
   task t_filter;
      int t0, t1;
      logic [2:0] seen;
      t0 = 99;
      t1 = 99;
      seen = 3'h0;
      apb(1'b1, OFS_FLAGS, 32'h8);
      src.level(3'h3, 1'b0);
      for (int n = 0; n < 12; n++) begin
         @(negedge clk);
         if (filt[0] === 1'b1 && t0 == 99) t0 = n;
         if (filt[1] === 1'b1 && t1 == 99) t1 = n;
      end
      chk("unfiltered delay", 32'd3, t1);
      chk("filtered delay", 32'd6, t0);
      src.level(3'h0, 1'b0);
      repeat (12) @(posedge clk);
      src.level(3'h3, 1'b0);
      src.level(3'h0, 1'b0);
      for (int n = 0; n < 12; n++) begin
         @(negedge clk);
         seen = seen | filt;
      end
      chk("short pulse", 32'h2, {29'h0, seen});
      $display("test filter done");
   endtask
   task finish_test;
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #100000;
      n_errors++;
      finish_test;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_events;
      t_irq;
      t_dir;
      t_filter;
      finish_test;
   end
endmodule
